// *** verilog/vectored_interrupt_acknowledge.sv ***
/*
 * interrupt acknowledge and priority logic: line zero noise filter,
 * status word, pending/mask/level flags, nmi, maskable and break
 * trap acknowledge, nesting control, classic wishbone slave.
 * assumes: the sequencer pulses instrDone at each instruction end,
 * pushes the status word then the program counter on ack, and
 * sampleTick is the selected sampling clock as a one-cycle enable.
 */
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "via_consts.svh"

module vectored_interrupt_acknowledge
  import via_pkg::*;
#(
  parameter int NSRC = `NUM_SRC
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  // wishbone classic slave
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [4:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  // request sources
  input  wire logic            extRequestLineZero,
  input  wire logic            sampleTick,
  input  wire logic [NSRC-1:0] sourceFire,
  input  wire logic            nmiFire,
  // sequencer side
  input  wire logic            instrDone,
  input  wire logic            breakTrapInstruction,
  input  wire logic            vectoredReturn,
  input  wire logic            breakReturn,
  input  wire psw_op_s         pswOp,
  output ack_s                 ack,
  output logic      [7:0]      programStatusWord
);

  logic [7:0]      psw_reg;      // status word
  logic [NSRC-1:0] pend_reg;     // pending flags
  logic [NSRC-1:0] mask_reg;     // mask flags
  logic [NSRC-1:0] level_reg;    // level select flags
  logic            nmiSvc_reg;   // nmi routine running
  logic            nmiHeld_reg;  // one held nmi
  logic            holdOne_reg;  // skip one boundary
  arb_e            state_reg;    // arbiter state
  logic [4:0]      lowSrc_reg;   // low-level winner
  ack_s            ack_reg;      // ack output flop
  logic            wbAck_reg;    // bus ack
  logic [31:0]     rdat_reg;     // bus read data
  logic            smp1_reg;     // first filter sample
  logic            smp2_reg;     // second filter sample
  logic            filt_reg;     // filtered level
  logic            filtPrev_reg; // for edge detect

  logic [NSRC-1:0] elig;         // pending and unmasked
  logic            hiFound;      // eligible high request
  logic            loFound;      // eligible low request
  logic [4:0]      hiIdx;        // best high index
  logic [4:0]      loIdx;        // best low index
  logic            boundary;     // usable boundary
  logic            takeNmi;      // accept nmi now
  logic            takeHi;       // accept high now
  logic            startLo;      // begin low accept
  logic            takeLo;       // finish low accept
  logic            takeBrk;      // break trap now
  logic            busWr;        // bus write strobe
  logic [NSRC-1:0] swClr;        // software pending clear
  logic [NSRC-1:0] accClr;       // acknowledge clear
  logic [NSRC-1:0] line0Set;     // filtered line zero

  assign programStatusWord = psw_reg;
  assign ack               = ack_reg;
  assign wb_ack_o          = wbAck_reg;
  assign wb_dat_o          = rdat_reg;

  // noise filter: sample only on the selected sampling enable
  // a one-sample glitch never reaches the filtered level, so a
  // pulse shorter than the sampling period leaves pending clear;
  // the price is a set that lags the line by up to three samples
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp1_reg     <= 1'b0;
      smp2_reg     <= 1'b0;
      filt_reg     <= 1'b0;
      filtPrev_reg <= 1'b0;
    end else begin
      if (sampleTick) begin
        smp1_reg <= extRequestLineZero;
        smp2_reg <= smp1_reg;
        // level changes only after two equal samples
        if (smp1_reg == smp2_reg)
          filt_reg <= smp2_reg;
      end
      filtPrev_reg <= filt_reg;
    end
  end

  // edge detect after filtering, feeds pending bit 0
  // both flops reset low like the idle pin: no false edge at start
  always_comb begin
    line0Set    = '0;
    line0Set[0] = filt_reg & ~filtPrev_reg;
  end

  // eligibility per source
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : gElig
      assign elig[g] = pend_reg[g] & ~mask_reg[g];
    end
  endgenerate

  // priority encode: lowest index wins within each level
  // scanning down from the top lets a lower index overwrite,
  // which gives the fixed default order without a second pass
  always_comb begin
    hiFound = 1'b0;
    loFound = 1'b0;
    hiIdx   = '0;
    loIdx   = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (elig[i] && !level_reg[i]) begin
        hiFound = 1'b1;
        hiIdx   = 5'(i);
      end
      if (elig[i] && level_reg[i]) begin
        loFound = 1'b1;
        loIdx   = 5'(i);
      end
    end
  end

  // acceptance decisions
  // the nmi, high and low-start signals are decided from flag values at the boundary,
  // so an op landing on the same edge acts on the next boundary
  always_comb begin
    takeBrk  = breakTrapInstruction;
    // one boundary after a return is always skipped
    boundary = instrDone & ~holdOne_reg &
               ~takeBrk & (state_reg == ST_IDLE);
    // nmi needs no enable; blocked only by own service
    takeNmi  = boundary & nmiHeld_reg & ~nmiSvc_reg;
    // maskable needs enable and no nmi in service
    takeHi   = boundary & ~takeNmi & hiFound &
               psw_reg[`PSW_IE] & ~nmiSvc_reg;
    // high first; low only when in-service flag is one
    startLo  = boundary & ~takeNmi & ~hiFound & loFound &
               psw_reg[`PSW_IE] & psw_reg[`PSW_ISP] &
               ~nmiSvc_reg;
    // a break trap in the wait clock wins; the low request stays
    // pending and is arbitrated again at a later boundary
    takeLo   = (state_reg == ST_LOW) & ~takeBrk;
  end

  // arbiter: low level takes one extra clock to start
  // boundaries seen during the wait clock are ignored, so a low
  // accept can never overlap a second decision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg  <= ST_IDLE;
      lowSrc_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (startLo) begin
            state_reg  <= ST_LOW;
            lowSrc_reg <= loIdx;
          end
        end
        ST_LOW: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge output: pushed status word taken before update
  // break beats nmi beats low wait beats high when they coincide
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= '0;
    end else begin
      ack_reg.valid   <= takeBrk | takeNmi | takeHi | takeLo;
      ack_reg.pushPsw <= psw_reg;
      if (takeBrk) begin
        ack_reg.kind   <= ACK_BRK;
        ack_reg.source <= '0;
        ack_reg.vector <= `VEC_BRK;
      end else if (takeNmi) begin
        ack_reg.kind   <= ACK_NMI;
        ack_reg.source <= '0;
        ack_reg.vector <= `VEC_NMI;
      end else if (takeLo) begin
        ack_reg.kind   <= ACK_MASK;
        ack_reg.source <= lowSrc_reg;
        ack_reg.vector <= `VEC_BASE +
          {10'h000, lowSrc_reg, 1'b0};
      end else if (takeHi) begin
        ack_reg.kind   <= ACK_MASK;
        ack_reg.source <= hiIdx;
        ack_reg.vector <= `VEC_BASE +
          {10'h000, hiIdx, 1'b0};
      end else begin
        ack_reg.kind <= ACK_NONE;
      end
    end
  end

  // status word: accept effects override core and bus writes
  // later statements win, so an enable set on the accept edge
  // is lost on purpose: the handler starts with accepts disabled
  // bit 2 is forced to zero by the write mask on every path
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      psw_reg <= `PSW_RESET;
    end else begin
      if (pswOp.restore)
        psw_reg <= pswOp.stackPsw & `PSW_WMASK;
      else if (pswOp.write)
        psw_reg <= pswOp.wrData & `PSW_WMASK;
      else if (busWr && wb_adr_i == `OFF_PSW && wb_sel_i[0])
        psw_reg <= wb_dat_i[7:0] & `PSW_WMASK;
      if (pswOp.setIe)
        psw_reg[`PSW_IE] <= 1'b1;
      if (pswOp.clrIe)
        psw_reg[`PSW_IE] <= 1'b0;
      if (takeBrk || takeHi || takeLo)
        psw_reg[`PSW_IE] <= 1'b0;
      if (takeHi)
        psw_reg[`PSW_ISP] <= 1'b0;
      if (takeLo)
        psw_reg[`PSW_ISP] <= 1'b1;
      if (takeNmi) begin
        psw_reg[`PSW_IE]  <= 1'b0;
        psw_reg[`PSW_ISP] <= 1'b0;
      end
    end
  end

  // nmi service tracking; a second request only keeps one held
  // the held flag is one bit, so any number of repeats collapse
  // into a single accept after the routine returns
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmiSvc_reg  <= 1'b0;
      nmiHeld_reg <= 1'b0;
    end else begin
      if (takeNmi)
        nmiSvc_reg <= 1'b1;
      else if (vectoredReturn)
        nmiSvc_reg <= 1'b0;
      // set wins over the clear at acceptance
      if (nmiFire)
        nmiHeld_reg <= 1'b1;
      else if (takeNmi)
        nmiHeld_reg <= 1'b0;
    end
  end

  // one main instruction must run after any return
  // the return pulse beats a boundary on the same edge, so the
  // skipped boundary is always the one after the return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdOne_reg <= 1'b0;
    end else begin
      if (vectoredReturn || breakReturn)
        holdOne_reg <= 1'b1;
      else if (instrDone)
        holdOne_reg <= 1'b0;
    end
  end

  // pending flags: set wins over clears; refused ones stay
  // a source firing on its own accept edge is kept, not lost
  // software clears by writing ones to the pending offset
  always_comb begin
    accClr = '0;
    if (takeHi)
      accClr[hiIdx] = 1'b1;
    if (takeLo)
      accClr[lowSrc_reg] = 1'b1;
    swClr = '0;
    if (busWr && wb_adr_i == `OFF_PEND)
      swClr = wb_dat_i[NSRC-1:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg <= `PEND_RESET;
    end else begin
      pend_reg <= (pend_reg & ~(accClr | swClr)) |
                  sourceFire | line0Set;
    end
  end

  // mask and level flags, written whole
  // both reset to all ones: everything masked and at low level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_reg  <= `MASK_RESET;
      level_reg <= `LEVEL_RESET;
    end else begin
      if (busWr && wb_adr_i == `OFF_MASK)
        mask_reg <= wb_dat_i[NSRC-1:0];
      if (busWr && wb_adr_i == `OFF_LEVEL)
        level_reg <= wb_dat_i[NSRC-1:0];
    end
  end

  // write takes effect at the edge where ack is seen high
  assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & wbAck_reg;

  // wishbone: ack one cycle after request, then drop
  // read data is captured with the ack and cleared after it, so
  // the bus shows zero whenever no answer stands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wbAck_reg <= 1'b0;
      rdat_reg  <= '0;
    end else begin
      wbAck_reg <= wb_cyc_i & wb_stb_i & ~wbAck_reg;
      rdat_reg  <= '0;
      if (wb_cyc_i && wb_stb_i && !wbAck_reg) begin
        case (wb_adr_i)
          `OFF_PSW:    rdat_reg[7:0]      <= psw_reg;
          `OFF_PEND:   rdat_reg[NSRC-1:0] <= pend_reg;
          `OFF_MASK:   rdat_reg[NSRC-1:0] <= mask_reg;
          `OFF_LEVEL:  rdat_reg[NSRC-1:0] <= level_reg;
          `OFF_STATUS: rdat_reg[3:0] <= {holdOne_reg,
                         state_reg == ST_LOW,
                         nmiHeld_reg, nmiSvc_reg};
          default:     rdat_reg <= '0;       // unmapped reads 0
        endcase
      end
    end
  end

endmodule

// *** verilog/via_consts.svh ***
/*
 * constants of the vectored interrupt acknowledge block:
 * register offsets, field positions, reset values, vectors.
 * assumes inclusion by bare name from the design file.
 */
`ifndef VIA_CONSTS_SVH
`define VIA_CONSTS_SVH

// wishbone byte offsets
`define OFF_PSW      5'h00
`define OFF_PEND     5'h04
`define OFF_MASK     5'h08
`define OFF_LEVEL    5'h0C
`define OFF_STATUS   5'h10

// status word fields
`define PSW_IE       7
`define PSW_ZERO     6
`define PSW_BSH      5
`define PSW_AC       4
`define PSW_BSL      3
`define PSW_FIX0     2
`define PSW_ISP      1
`define PSW_CY       0
`define PSW_RESET    8'h02
`define PSW_WMASK    8'hFB

// source count and reset values
`define NUM_SRC      19
`define PEND_RESET   19'h00000
`define MASK_RESET   19'h7FFFF
`define LEVEL_RESET  19'h7FFFF

// vectors
`define VEC_NMI      16'h0004
`define VEC_BASE     16'h0006
`define VEC_BRK      16'h003E

// latency in cpu clocks, request to service start
`define LAT_HIGH_MIN 7
`define LAT_HIGH_MAX 32
`define LAT_LOW_MIN  8
`define LAT_LOW_MAX  33

`endif

// *** verilog/via_pkg.sv ***
/*
 * types of the vectored interrupt acknowledge block.
 * assumes via_consts.svh for numbers.
 */
package via_pkg;

  // kind of acknowledge
  typedef enum logic [1:0] {
    ACK_NONE = 2'h0,
    ACK_NMI  = 2'h1,
    ACK_MASK = 2'h2,
    ACK_BRK  = 2'h3
  } ack_kind_e;

  // acknowledge carrier toward the sequencer
  typedef struct packed {
    logic        valid;
    ack_kind_e   kind;
    logic [4:0]  source;
    logic [15:0] vector;
    logic [7:0]  pushPsw;
  } ack_s;

  // core-side status word operations
  typedef struct packed {
    logic       setIe;
    logic       clrIe;
    logic       write;
    logic [7:0] wrData;
    logic       restore;
    logic [7:0] stackPsw;
  } psw_op_s;

  // arbiter states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_LOW  = 2'b10
  } arb_e;

endpackage

// *** tb/via_chk.sv ***
/* checker of the acknowledge block, bound to its top module.
   assumes via_pkg is compiled first. */
`timescale 1ns/1ps
module via_chk
  import via_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       instrDone,
  input wire logic       breakTrapInstruction,
  input wire psw_op_s    pswOp,
  input wire ack_s       ack,
  input wire logic [7:0] programStatusWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // break answer on the next edge
  sequence brkAck;
    ack.valid && ack.kind == ACK_BRK && ack.vector == 16'h003E;
  endsequence
  // enable set alone, no overriding write
  sequence plainSet;
    pswOp.setIe && !pswOp.clrIe && !pswOp.write && !pswOp.restore;
  endsequence
  reset_value_a: assert property (
    $rose(rst_n) |-> programStatusWord == 8'h02)
    else $error("status word wrong after reset");
  fixed_zero_a: assert property (
    programStatusWord[2] == 1'b0)
    else $error("status word bit 2 not zero");
  accept_clears_a: assert property (
    ack.valid |-> !programStatusWord[7])
    else $error("enable left set on accept");
  push_old_a: assert property (
    ack.valid |-> ack.pushPsw == $past(programStatusWord))
    else $error("pushed status word not the old one");
  nmi_accept_a: assert property (
    ack.valid && ack.kind == ACK_NMI
      |-> programStatusWord[1] == 1'b0 && ack.vector == 16'h0004)
    else $error("nmi accept wrong");
  mask_vector_a: assert property (
    ack.valid && ack.kind == ACK_MASK
      |-> ack.vector == 16'h0006 + {10'h000, ack.source, 1'b0})
    else $error("maskable vector wrong");
  break_ack_a: assert property (
    breakTrapInstruction |=> brkAck)
    else $error("break trap not answered");
  boundary_only_a: assert property (
    ack.valid |-> $past(instrDone) || $past(instrDone, 2)
      || $past(breakTrapInstruction))
    else $error("accept away from a boundary");
  enable_set_a: assert property (
    plainSet |=> programStatusWord[7] || ack.valid)
    else $error("enable set op lost");
endmodule

bind vectored_interrupt_acknowledge via_chk u_chk (
  .clk(clk), .rst_n(rst_n), .instrDone(instrDone),
  .breakTrapInstruction(breakTrapInstruction), .pswOp(pswOp),
  .ack(ack), .programStatusWord(programStatusWord));

// *** tb/seq_model.sv ***
/* sequencer stand-in: instruction boundaries and returns.
   assumes the ack carrier of the acknowledge block. */
`timescale 1ns/1ps
module seq_model
  import via_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic retReq,
  input  wire ack_s ack,
  output logic      instrDone,
  output logic      vectoredReturn,
  output logic      breakReturn
);
  logic [1:0] phaseReg; // cycle within instruction
  ack_kind_e  lastReg;  // kind of latest accept
  // one boundary every four cycles while running
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseReg  <= 2'h0;
      instrDone <= 1'b0;
    end else begin
      phaseReg  <= phaseReg + 2'h1;
      instrDone <= run && phaseReg == 2'h3;
    end
  end
  // trap handler leaves by break return, others by vectored return
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lastReg        <= ACK_NONE;
      vectoredReturn <= 1'b0;
      breakReturn    <= 1'b0;
    end else begin
      if (ack.valid) lastReg <= ack.kind;
      vectoredReturn <= retReq && lastReg != ACK_BRK;
      breakReturn    <= retReq && lastReg == ACK_BRK;
    end
  end
endmodule

// *** tb/tb.sv ***
/* bench of the acknowledge block: bus accesses, pulses, checks.
   assumes seq_model as sequencer and via_chk bound to the top. */
`timescale 1ns/1ps
`include "via_consts.svh"
module tb
  import via_pkg::*;
;
  logic        clk, rst_n, wbCyc, wbStb, wbWe, wbAck, lineZero, tick;
  logic [4:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDat, wbQ;
  logic [18:0] fire;
  logic        nmiFire, brkOp, run, retReq, instrDone, vRet, bRet;
  psw_op_s     pswOp;
  ack_s        ack;
  logic [7:0]  program_status_word;
  int          errCount, nCompared;

  vectored_interrupt_acknowledge i_dut (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
    .wb_dat_o(wbQ), .wb_ack_o(wbAck), .extRequestLineZero(lineZero),
    .sampleTick(tick), .sourceFire(fire), .nmiFire(nmiFire),
    .instrDone(instrDone), .breakTrapInstruction(brkOp),
    .vectoredReturn(vRet), .breakReturn(bRet), .pswOp(pswOp),
    .ack(ack), .programStatusWord(program_status_word));
  seq_model i_seq (.clk(clk), .rst_n(rst_n), .run(run),
    .retReq(retReq), .ack(ack), .instrDone(instrDone),
    .vectoredReturn(vRet), .breakReturn(bRet));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic report_and_stop;
    if (errCount == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbSel <= 4'hF;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbQ;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [4:0] a,
                    input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // {nmi, break, enable set, return} pulse plus source pulses
  task automatic pulse(input logic [3:0] w, input logic [18:0] v);
    @(posedge clk);
    {nmiFire, brkOp, pswOp.setIe, retReq} <= w;
    fire <= v;
    @(posedge clk);
    {nmiFire, brkOp, pswOp.setIe, retReq} <= 4'h0;
    fire <= 19'h00000;
  endtask

  // one-cycle status word operation from the core side
  task automatic op(input psw_op_s o);
    @(posedge clk);
    pswOp <= o;
    @(posedge clk);
    pswOp <= '0;
    @(posedge clk);
  endtask

  task automatic smp(input logic lvl);
    @(posedge clk);
    lineZero <= lvl;
    tick     <= 1'b1;
    @(posedge clk);
    tick     <= 1'b0;
  endtask

  task automatic waitAck(input logic [1:0] k, input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack.valid !== 1'b1 && n < 100);
    chk("ack kind", ack.kind, k);
    chk("ack vector", ack.vector, v);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      chk("no ack", ack.valid, 32'h0);
    end
  endtask

  initial begin
    #800000;
    errCount++;
    report_and_stop();
  end

  initial begin
    {rst_n, wbCyc, wbStb, wbWe, lineZero, tick} = 6'h00;
    {nmiFire, brkOp, run, retReq} = 4'h0;
    wbAdr = 5'h00;
    wbSel = 4'h0;
    wbDat = 32'h0;
    fire  = 19'h00000;
    pswOp = '0;
    errCount  = 0;
    nCompared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd("psw", `OFF_PSW, 32'h02);
    rd("pend", `OFF_PEND, 32'h0);
    rd("mask", `OFF_MASK, 32'h7FFFF);
    rd("level", `OFF_LEVEL, 32'h7FFFF);
    rd("unmapped", 5'h14, 32'h0);
    smp(1'b1);
    smp(1'b0);
    smp(1'b0);
    rd("short pulse", `OFF_PEND, 32'h0);
    smp(1'b1);
    smp(1'b1);
    smp(1'b0);
    rd("long pulse", `OFF_PEND, 32'h1);
    wr(`OFF_PSW, 32'hFF);
    rd("psw fields", `OFF_PSW, 32'hFB);
    chk("psw port", program_status_word, 32'hFB);
    wr(`OFF_MASK, 32'h7FFC7);
    wr(`OFF_LEVEL, 32'h7FFCF);
    wr(`OFF_PSW, 32'h82);
    run <= 1'b1;
    pulse(4'h0, 19'h00028);
    waitAck(ACK_MASK, 16'h0010);
    chk("psw high", program_status_word, 32'h00);
    rd("held low", `OFF_PEND, 32'h9);
    pulse(4'h2, 19'h00000);
    quiet(16);
    pulse(4'h0, 19'h00010);
    waitAck(ACK_MASK, 16'h000E);
    wr(`OFF_PSW, 32'h82);
    waitAck(ACK_MASK, 16'h000C);
    chk("psw low", program_status_word, 32'h02);
    wr(`OFF_PSW, 32'h02);
    pulse(4'h8, 19'h00000);
    waitAck(ACK_NMI, 16'h0004);
    chk("psw nmi", program_status_word, 32'h00);
    pulse(4'h2, 19'h00000);
    pulse(4'h8, 19'h00010);
    pulse(4'h8, 19'h00000);
    quiet(20);
    rd("status nmi", `OFF_STATUS, 32'h3);
    pulse(4'h1, 19'h00000);
    waitAck(ACK_NMI, 16'h0004);
    pulse(4'h1, 19'h00000);
    quiet(20);
    pulse(4'h2, 19'h00000);
    waitAck(ACK_MASK, 16'h000E);
    pulse(4'h2, 19'h00000);
    pulse(4'h4, 19'h00000);
    waitAck(ACK_BRK, 16'h003E);
    chk("psw enable", program_status_word[7], 32'h0);
    op('{restore: 1'b1, stackPsw: 8'hFF, default: '0});
    chk("psw restore", program_status_word, 32'hFB);
    op('{clrIe: 1'b1, default: '0});
    chk("psw clear", program_status_word, 32'h7B);
    op('{write: 1'b1, wrData: 8'h06, default: '0});
    chk("psw write", program_status_word, 32'h02);
    pulse(4'h1, 19'h00000);
    rd("status", `OFF_STATUS, 32'h8);
    wr(`OFF_PEND, 32'h1);
    rd("pend clear", `OFF_PEND, 32'h0);
    report_and_stop();
  end
endmodule
